//--- hdl/itv_consts.svh
`ifndef ITV_CONSTS_SVH
`define ITV_CONSTS_SVH

// register byte offsets
`define ITV_OFS_TRAP_STS 8'h00
`define ITV_OFS_VEC_STS 8'h04
`define ITV_OFS_PRIO 8'h08
`define ITV_OFS_INT_STS 8'h0C
`define ITV_OFS_INT_MASK 8'h10

// trap status bits
`define ITV_BIT_SOFT_HARD_TRAP_FLAG 0
`define ITV_BIT_ECC 1

// vector status fields
`define ITV_BIT_UNACK 15
`define ITV_BIT_VECTOR_CAPTURE_SELECT 13
`define ITV_ILR_HI 11
`define ITV_ILR_LO 8
`define ITV_VEC_HI 7
`define ITV_VEC_LO 0

// priority control fields
`define ITV_IPL_HI 2
`define ITV_IPL_LO 0
`define ITV_IPL_TOP 3

// event status bits
`define ITV_EV_SOFT_HARD_TRAP_FLAG 0
`define ITV_EV_ECC 1
`define ITV_EV_UNACK 2
`define ITV_EV_W 3

// trap vectors in trap index order
`define ITV_VEC_OSC 8'h00
`define ITV_VEC_ADDR 8'h01
`define ITV_VEC_HARD 8'h02
`define ITV_VEC_STACK 8'h03
`define ITV_VEC_MATH 8'h04
`define ITV_VEC_SOFT 8'h06
`define ITV_VEC_USER_BASE 8'h08
`define ITV_VEC_RESERVED_TOP 255
`define ITV_NTRAP 6

// levels
`define ITV_TRAP_TOP_LVL 4'hF
`define ITV_LVL_ZERO 4'h0
`define ITV_VEC_ZERO 8'h00
`define ITV_ZERO32 32'h0000_0000

`endif

//--- hdl/itv_pkg.sv
`include "itv_consts.svh"

package itv_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } itv_apb_e;

  typedef logic [7:0] itv_vec_t;
  typedef logic [3:0] itv_lvl_t;

  function automatic itv_vec_t itv_trap_vec(input int idx);
    case (idx)
      0: itv_trap_vec = `ITV_VEC_OSC;
      1: itv_trap_vec = `ITV_VEC_ADDR;
      2: itv_trap_vec = `ITV_VEC_HARD;
      3: itv_trap_vec = `ITV_VEC_STACK;
      4: itv_trap_vec = `ITV_VEC_MATH;
      default: itv_trap_vec = `ITV_VEC_SOFT;
    endcase
  endfunction

endpackage

//--- hdl/itv_arb_if.sv
`timescale 1ns/10ps
`include "itv_consts.svh"

interface itv_arb_if #(parameter int NSRC = 8);
  logic [`ITV_NTRAP-1:0] trap_pend;
  logic [NSRC-1:0] src_pend;
  logic [3*NSRC-1:0] src_prio;
  logic win_valid;
  logic [7:0] win_vec;
  logic [3:0] win_lvl;

  modport requester (
    output trap_pend, src_pend, src_prio,
    input win_valid, win_vec, win_lvl
  );
  modport resolver (
    input trap_pend, src_pend, src_prio,
    output win_valid, win_vec, win_lvl
  );
endinterface

//--- hdl/itv_resolver.sv
`timescale 1ns/10ps
`include "itv_consts.svh"

module itv_resolver
  import itv_pkg::*;
#(
  parameter int NSRC = 8
) (
  itv_arb_if.resolver arb
);

  // traps beat every user source; among traps the lower vector wins
  always_comb begin
    logic found;
    itv_lvl_t best_lvl;
    itv_vec_t best_vec;
    found = 1'b0;
    best_lvl = `ITV_LVL_ZERO;
    best_vec = `ITV_VEC_ZERO;
    for (int i = 0; i < `ITV_NTRAP; i++) begin
      if (arb.trap_pend[i] && !found) begin
        found = 1'b1;
        best_vec = itv_trap_vec(i);
        best_lvl = `ITV_TRAP_TOP_LVL - 4'(i);
      end
    end
    // user level 0 means disabled; ties go to the lower vector
    for (int j = 0; j < NSRC; j++) begin
      if (!found && arb.src_pend[j] && ({1'b0, arb.src_prio[3*j +: 3]} > best_lvl)) begin
        best_lvl = {1'b0, arb.src_prio[3*j +: 3]};
        best_vec = `ITV_VEC_USER_BASE + 8'(j);
      end
    end
    arb.win_valid = found || (best_lvl != `ITV_LVL_ZERO);
    arb.win_vec = best_vec;
    arb.win_lvl = best_lvl;
  end

endmodule // itv_resolver

//--- hdl/itv_status.sv
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "itv_consts.svh"

// Overview of operation
// - ECC double-error trap sets clearable flag bit1
// - software hard trap sets clearable flag bit0
// - bit15 shows request blocked by CPU priority
// - capture bit set: show highest pending vector
// - capture bit clear: hold last acknowledged vector
// - bits 11..8 report new CPU priority level
// - oscillator 0, address 1, hard trap 2
// - stack 3, math 4, soft error 6
// - vectors 5, 7, 255 never assigned
// - user vectors start at 8, ascending
// - CPU level is top bit plus 3-bit field
// - top priority bit is read-only to software
module itv_status
  import itv_pkg::*;
#(
  parameter int NSRC = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core side
  input wire logic [`ITV_NTRAP-1:0] trap_pend,
  input wire logic [NSRC-1:0] src_pend,
  input wire logic [3*NSRC-1:0] src_prio,
  input wire logic ecc_double_error_evt,
  input wire logic soft_hard_trap_evt,
  input wire logic cpu_ack,
  input wire logic trap_return,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [3:0] irq_level,
  output logic [3:0] cpu_priority_level,
  output logic request_unacknowledged,
  // interrupt
  output logic irq
);

  // user vectors must never reach the reserved top code
  if (NSRC < 1 || NSRC + 8 > `ITV_VEC_RESERVED_TOP) begin : g_chk
    $error("itv_status: NSRC out of range");
  end

  itv_arb_if #(.NSRC(NSRC)) arb ();

  assign arb.trap_pend = trap_pend;
  assign arb.src_pend = src_pend;
  assign arb.src_prio = src_prio;

  itv_resolver #(.NSRC(NSRC)) u_resolver (
    .arb(arb)
  );

  // ---------------- apb slave ----------------
  itv_apb_e st_ff, nxt_st;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic wr_commit;
  logic addr_ok;

  function automatic logic itv_hit(input logic [7:0] a);
    itv_hit = (a == `ITV_OFS_TRAP_STS) || (a == `ITV_OFS_VEC_STS) ||
              (a == `ITV_OFS_PRIO) || (a == `ITV_OFS_INT_STS) ||
              (a == `ITV_OFS_INT_MASK);
  endfunction

  function automatic logic itv_wr(input logic [7:0] a, input logic en, input logic [7:0] ofs);
    itv_wr = en && (a == ofs);
  endfunction

  assign addr_ok = itv_hit(paddr);
  // write lands only on the edge that also completes the transfer
  assign wr_commit = (st_ff == ST_DONE) && psel && penable && pwrite && addr_ok;

  // ---------------- state ----------------
  logic ecc_ff, nxt_ecc;
  logic soft_hard_trap_flag_ff, nxt_soft_hard_trap_flag;
  logic vector_capture_select_ff, nxt_vector_capture_select;
  logic [2:0] ipl_ff, nxt_ipl;
  logic top_ff, nxt_top;
  logic [7:0] last_vec_ff, nxt_last_vec;
  logic [3:0] ilr_ff, nxt_ilr;
  logic unack_ff, nxt_unack;
  logic irq_req_ff, nxt_irq_req;
  logic [7:0] irq_vec_ff, nxt_irq_vec;
  logic [3:0] irq_lvl_ff, nxt_irq_lvl;
  logic [`ITV_EV_W-1:0] ev_sts_ff, nxt_ev_sts;
  logic [`ITV_EV_W-1:0] ev_mask_ff, nxt_ev_mask;
  logic irq_ff, nxt_irq;

  logic [3:0] cpu_lvl;
  logic [7:0] vec_view;
  logic [31:0] rd_word;
  logic [`ITV_EV_W-1:0] ev_set;

  assign cpu_lvl = {top_ff, ipl_ff};
  // capture select picks live winner or the held acknowledged vector
  assign vec_view = vector_capture_select_ff ? arb.win_vec : last_vec_ff;

  always_comb begin
    rd_word = `ITV_ZERO32;
    case (paddr)
      `ITV_OFS_TRAP_STS: begin
        rd_word[`ITV_BIT_ECC] = ecc_ff;
        rd_word[`ITV_BIT_SOFT_HARD_TRAP_FLAG] = soft_hard_trap_flag_ff;
      end
      `ITV_OFS_VEC_STS: begin
        rd_word[`ITV_BIT_UNACK] = unack_ff;
        rd_word[`ITV_BIT_VECTOR_CAPTURE_SELECT] = vector_capture_select_ff;
        rd_word[`ITV_ILR_HI:`ITV_ILR_LO] = ilr_ff;
        rd_word[`ITV_VEC_HI:`ITV_VEC_LO] = vec_view;
      end
      `ITV_OFS_PRIO: begin
        rd_word[`ITV_IPL_HI:`ITV_IPL_LO] = ipl_ff;
        rd_word[`ITV_IPL_TOP] = top_ff;
      end
      `ITV_OFS_INT_STS: rd_word[`ITV_EV_W-1:0] = ev_sts_ff;
      `ITV_OFS_INT_MASK: rd_word[`ITV_EV_W-1:0] = ev_mask_ff;
      default: rd_word = `ITV_ZERO32;
    endcase
  end

  // two wait states: pready rises on the third access cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    case (st_ff)
      ST_IDLE: begin
        if (psel && penable) begin
          nxt_st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        nxt_st = ST_DONE;
        nxt_pready = 1'b1;
        nxt_pslverr = !addr_ok;
        nxt_prdata = (pwrite || !addr_ok) ? `ITV_ZERO32 : rd_word;
      end
      ST_DONE: begin
        nxt_st = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= `ITV_ZERO32;
    end else begin
      st_ff <= nxt_st;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------- trap flags and priority ----------------
  // a new event on the clearing edge keeps the flag set
  always_comb begin
    logic clr_ecc;
    logic clr_soft_hard_trap_flag;
    logic wr_trap;
    logic wr_vec;
    logic wr_prio;
    wr_trap = itv_wr(paddr, wr_commit, `ITV_OFS_TRAP_STS);
    wr_vec = itv_wr(paddr, wr_commit, `ITV_OFS_VEC_STS);
    wr_prio = itv_wr(paddr, wr_commit, `ITV_OFS_PRIO);
    clr_ecc = wr_trap && pwdata[`ITV_BIT_ECC];
    clr_soft_hard_trap_flag = wr_trap && pwdata[`ITV_BIT_SOFT_HARD_TRAP_FLAG];
    nxt_ecc = ecc_double_error_evt || (ecc_ff && !clr_ecc);
    nxt_soft_hard_trap_flag = soft_hard_trap_evt || (soft_hard_trap_flag_ff && !clr_soft_hard_trap_flag);
    nxt_vector_capture_select = wr_vec ? pwdata[`ITV_BIT_VECTOR_CAPTURE_SELECT] : vector_capture_select_ff;
    // software reaches only the low three level bits
    nxt_ipl = wr_prio ? pwdata[`ITV_IPL_HI:`ITV_IPL_LO] : ipl_ff;
    nxt_top = top_ff;
    nxt_last_vec = last_vec_ff;
    nxt_ilr = ilr_ff;
    // acknowledge raises the cpu level to the taken request, over software
    if (cpu_ack && irq_req_ff) begin
      nxt_last_vec = irq_vec_ff;
      nxt_ilr = irq_lvl_ff;
      nxt_ipl = irq_lvl_ff[2:0];
      nxt_top = irq_lvl_ff[3];
    end else if (trap_return) begin
      nxt_top = 1'b0;
    end
  end

  // ---------------- request towards the core ----------------
  always_comb begin
    nxt_irq_req = arb.win_valid && (arb.win_lvl > cpu_lvl);
    nxt_irq_vec = arb.win_vec;
    nxt_irq_lvl = arb.win_lvl;
    // pending but masked by an equal or higher cpu level
    nxt_unack = arb.win_valid && (arb.win_lvl <= cpu_lvl);
    if (cpu_ack && irq_req_ff) begin
      nxt_irq_req = 1'b0;
    end
  end

  // ---------------- event status, mask, interrupt ----------------
  always_comb begin
    logic wr_sts;
    logic wr_mask;
    wr_sts = itv_wr(paddr, wr_commit, `ITV_OFS_INT_STS);
    wr_mask = itv_wr(paddr, wr_commit, `ITV_OFS_INT_MASK);
    ev_set = '0;
    ev_set[`ITV_EV_SOFT_HARD_TRAP_FLAG] = soft_hard_trap_evt;
    ev_set[`ITV_EV_ECC] = ecc_double_error_evt;
    ev_set[`ITV_EV_UNACK] = nxt_unack && !unack_ff;
    nxt_ev_sts = ev_sts_ff;
    if (wr_sts) begin
      nxt_ev_sts = ev_sts_ff & ~pwdata[`ITV_EV_W-1:0];
    end
    nxt_ev_sts = nxt_ev_sts | ev_set;
    nxt_ev_mask = wr_mask ? pwdata[`ITV_EV_W-1:0] : ev_mask_ff;
    nxt_irq = |(nxt_ev_sts & nxt_ev_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_ff <= 1'b0;
      soft_hard_trap_flag_ff <= 1'b0;
      vector_capture_select_ff <= 1'b0;
      ipl_ff <= 3'h0;
      top_ff <= 1'b0;
      last_vec_ff <= `ITV_VEC_ZERO;
      ilr_ff <= `ITV_LVL_ZERO;
      unack_ff <= 1'b0;
      irq_req_ff <= 1'b0;
      irq_vec_ff <= `ITV_VEC_ZERO;
      irq_lvl_ff <= `ITV_LVL_ZERO;
      ev_sts_ff <= '0;
      ev_mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ecc_ff <= nxt_ecc;
      soft_hard_trap_flag_ff <= nxt_soft_hard_trap_flag;
      vector_capture_select_ff <= nxt_vector_capture_select;
      ipl_ff <= nxt_ipl;
      top_ff <= nxt_top;
      last_vec_ff <= nxt_last_vec;
      ilr_ff <= nxt_ilr;
      unack_ff <= nxt_unack;
      irq_req_ff <= nxt_irq_req;
      irq_vec_ff <= nxt_irq_vec;
      irq_lvl_ff <= nxt_irq_lvl;
      ev_sts_ff <= nxt_ev_sts;
      ev_mask_ff <= nxt_ev_mask;
      irq_ff <= nxt_irq;
    end
  end

  // ---------------- outputs ----------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq_req = irq_req_ff;
  assign irq_vector = irq_vec_ff;
  assign irq_level = irq_lvl_ff;
  assign cpu_priority_level = {top_ff, ipl_ff};
  assign request_unacknowledged = unack_ff;
  assign irq = irq_ff;

endmodule // itv_status

//--- bench/itv_status_assertions.sv
`timescale 1ns/10ps
`include "itv_consts.svh"
module itv_status_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core side
  input wire logic [`ITV_NTRAP-1:0] trap_pend,
  input wire logic cpu_ack,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] cpu_priority_level,
  input wire logic request_unacknowledged
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  unack_excl_a: assert property (!(irq_req && request_unacknowledged))
    else $error("request both raised and blocked");
  ack_drop_a: assert property (cpu_ack && irq_req |=> !irq_req)
    else $error("request stands after acknowledge");
  ack_level_a: assert property (cpu_ack && irq_req |=> cpu_priority_level == $past(irq_level))
    else $error("level not taken on acknowledge");
  rsv_vec_a: assert property (irq_req |-> !(irq_vector inside {8'h05, 8'h07, 8'hFF}))
    else $error("reserved vector issued");
  osc_vec_a: assert property (irq_req && $past(trap_pend[0]) |-> irq_vector == 8'h00 && irq_level == 4'hF)
    else $error("oscillator trap vector wrong");
  soft_vec_a: assert property (irq_req && $past(trap_pend) == 6'h20 |-> irq_vector == 8'h06 && irq_level == 4'hA)
    else $error("soft error trap vector wrong");
  user_base_a: assert property (irq_req && $past(trap_pend) == 6'h00 |-> irq_vector >= 8'h08)
    else $error("user vector below base");
  top_bit_a: assert property ($rose(cpu_priority_level[3]) |-> $past(cpu_ack))
    else $error("top level bit set without acknowledge");
  // one settled cycle first: the request register lags the level by one edge
  user_block_a: assert property (cpu_priority_level[3] && $past(cpu_priority_level[3])
    |-> !(irq_req && irq_vector >= 8'h08))
    else $error("user request while top bit set");
endmodule // itv_status_assertions

bind itv_status itv_status_assertions i_itv_status_assertions (.*);

//--- bench/itv_core_model.sv
`timescale 1ns/10ps
module itv_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // handshake
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  output logic cpu_ack
);
  logic [3:0] wait_ff;
  // slow core: acks only after ack_dly cycles of a standing request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 4'h0;
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= irq_req && ack_en && !cpu_ack && wait_ff == ack_dly;
      wait_ff <= (irq_req && !cpu_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule // itv_core_model

//--- bench/itv_status_tb.sv
`timescale 1ns/10ps
module itv_status_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cpu_ack, irq_req, request_unacknowledged, irq, ack_en = 1'b0;
  logic ecc_double_error_evt = 1'b0, soft_hard_trap_evt = 1'b0, trap_return = 1'b0;
  logic [5:0] trap_pend = 6'h00;
  logic [7:0] src_pend = 8'h00, irq_vector;
  logic [23:0] src_prio = 24'h0;
  logic [3:0] irq_level, cpu_priority_level, ack_dly = 4'h0;
  logic [7:0] tv [0:5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
  logic [32:0] exp_q [$];
  logic [2:0] p;
  int n_errors = 0, checked = 0;
  always #50 pclk = ~pclk;
  itv_status i_itv_status (.*);
  itv_core_model i_itv_core_model (.*);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // expectation is queued before the request, so the monitor never runs dry
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic ev(input logic [2:0] m);
    @(posedge pclk);
    {trap_return, ecc_double_error_evt, soft_hard_trap_evt} <= m;
    @(posedge pclk);
    {trap_return, ecc_double_error_evt, soft_hard_trap_evt} <= 3'h0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) chk(33'h1_FFFF_FFFF, 33'h0);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  initial begin
    void'($urandom(32'h68fb));
    tick(20);
    presetn <= 1'b1;
    rd(8'h00, 33'h0);
    rd(8'h04, 33'h0);
    rd(8'h14, 33'h1_0000_0000);
    $display("test reset done");
    wr(8'h10, 32'h3);
    ev(3'h3);
    rd(8'h00, 33'h3);
    chk({32'h0, irq}, 33'h1);
    wr(8'h00, 32'h2);
    rd(8'h00, 33'h1);
    wr(8'h00, 32'h3);
    rd(8'h00, 33'h0);
    wr(8'h0C, 32'h3);
    tick(2);
    chk({32'h0, irq}, 33'h0);
    wr(8'h10, 32'h0);
    ev(3'h1);
    rd(8'h00, 33'h1);
    chk({32'h0, irq}, 33'h0);
    $display("test flags done");
    for (int i = 0; i < 6; i++) begin
      trap_pend <= 6'h01 << i;
      tick(3);
      chk({20'h0, irq_req, irq_vector, irq_level}, {20'h0, 1'b1, tv[i], 4'(15 - i)});
    end
    trap_pend <= 6'h04;
    ack_dly <= 4'($urandom_range(5));
    ack_en <= 1'b1;
    tick(20);
    ack_en <= 1'b0;
    trap_pend <= 6'h00;
    rd(8'h08, 33'hD);
    wr(8'h08, 32'h0);
    rd(8'h08, 33'h8);
    rd(8'h04, 33'hD02);
    ev(3'h4);
    rd(8'h08, 33'h0);
    wr(8'h08, 32'hF);
    rd(8'h08, 33'h7);
    $display("test traps done");
    wr(8'h08, 32'h0);
    p = 3'($urandom_range(7, 1));
    src_prio <= {18'h0, p, 3'h0};
    src_pend <= 8'h02;
    ack_en <= 1'b1;
    tick(20);
    ack_en <= 1'b0;
    src_prio <= {21'h0, p};
    src_pend <= 8'h01;
    tick(3);
    chk({32'h0, request_unacknowledged}, 33'h1);
    rd(8'h04, {17'h0, 4'h8, 1'b0, p, 8'h09});
    wr(8'h04, 32'h2000);
    rd(8'h04, {17'h0, 4'hA, 1'b0, p, 8'h08});
    $display("test vectors done");
    test_done;
  end
  initial begin
    #3_000_000;
    n_errors++;
    test_done;
  end
endmodule // itv_status_tb
